// ===== mtc_pkg.sv
// shared constants and types for the metering threshold and configuration block
package mtc_pkg;

  localparam logic [7:0] OFS_PULSE_PRI    = 8'h00;
  localparam logic [7:0] OFS_PULSE_SEC    = 8'h01;
  localparam logic [7:0] OFS_START_PS     = 8'h02;
  localparam logic [7:0] OFS_START_Q      = 8'h03;
  localparam logic [7:0] OFS_VOLT_LOSS    = 8'h04;
  localparam logic [7:0] OFS_ZERO_CROSS   = 8'h05;
  localparam logic [7:0] OFS_REGION_LOW1  = 8'h06;
  localparam logic [7:0] OFS_REGION_HIGH1 = 8'h07;
  localparam logic [7:0] OFS_REGION_LOW2  = 8'h08;
  localparam logic [7:0] OFS_REGION_HIGH2 = 8'h09;
  localparam logic [7:0] OFS_ZONE_LOW     = 8'h0a;
  localparam logic [7:0] OFS_ZONE_HIGH    = 8'h0b;
  localparam logic [7:0] OFS_CAL_VOLT_A   = 8'h0c;
  localparam logic [7:0] OFS_CAL_VOLT_B   = 8'h0d;
  localparam logic [7:0] OFS_CAL_VOLT_C   = 8'h0e;
  localparam logic [7:0] OFS_CAL_CUR_A    = 8'h0f;
  localparam logic [7:0] OFS_CAL_CUR_B    = 8'h10;
  localparam logic [7:0] OFS_CAL_CUR_C    = 8'h11;
  localparam logic [7:0] OFS_CAL_NEUTRAL  = 8'h12;

  localparam logic [15:0] RST_PULSE_CONST = 16'h1000;
  localparam logic [15:0] RST_STARTUP     = 16'h0250;
  localparam logic [15:0] RST_VOLT_LOSS   = 16'h0400;
  localparam logic [15:0] RST_ZERO_CROSS  = 16'h0073;
  localparam logic [15:0] RST_REGION      = 16'h0000;
  localparam logic [15:0] RST_ZONE        = 16'h0000;
  localparam logic [7:0]  RST_CAL_BYTE    = 8'h80;
  localparam logic [23:0] RST_CAL_CUR     = 24'h808080;

  localparam int RMS_TOP     = 27;
  localparam int VLOSS_BOT   = 11;
  localparam int REGION_BOT  = 12;
  localparam int PHASE_CNT   = 3;
  localparam int PULSE_CNT   = 6;

  typedef enum logic [1:0] {RegionOne, RegionTwo, RegionThree} mtc_region_t;

  typedef struct packed {
    logic [15:0]      pulsePri;
    logic [15:0]      pulseSec;
    logic [15:0]      startPs;
    logic [15:0]      startQ;
    logic [15:0]      voltLoss;
    logic [15:0]      zeroCross;
    logic [15:0]      regionLow1;
    logic [15:0]      regionHigh1;
    logic [15:0]      regionLow2;
    logic [15:0]      regionHigh2;
    logic [15:0]      zoneLow;
    logic [15:0]      zoneHigh;
    logic [2:0][7:0]  calVolt;
    logic [2:0][23:0] calCur;
    logic [7:0]       calNeutral;
  } mtc_cfg_t;

  localparam mtc_cfg_t CFG_RESET = '{
    pulsePri: RST_PULSE_CONST, pulseSec: RST_PULSE_CONST,
    startPs: RST_STARTUP, startQ: RST_STARTUP,
    voltLoss: RST_VOLT_LOSS, zeroCross: RST_ZERO_CROSS,
    regionLow1: RST_REGION, regionHigh1: RST_REGION,
    regionLow2: RST_REGION, regionHigh2: RST_REGION,
    zoneLow: RST_ZONE, zoneHigh: RST_ZONE,
    calVolt: {3{RST_CAL_BYTE}}, calCur: {3{RST_CAL_CUR}}, calNeutral: RST_CAL_BYTE};

  typedef struct packed {
    logic [2:0][31:0] iRms;
    logic [2:0][31:0] fiRms;
    logic [2:0][31:0] uRms;
    logic [2:0][31:0] fuRms;
  } mtc_rms_t;

  typedef struct packed {
    logic [2:0] voltLoss;
    logic [2:0] startPs;
    logic [2:0] startFundPs;
    logic [2:0] startQ;
    logic [2:0] startFundQ;
    logic [2:0] zoneStatus;
    logic [2:0] zoneEvent;
    logic [5:0] zxOut;
  } mtc_flags_t;

  typedef struct packed {
    mtc_cfg_t               cfg;
    mtc_region_t [2:0]      region;
    mtc_flags_t             flags;
    logic [5:0]             pulse;
    logic [5:0]             energy;
    logic [2:0][23:0]       angle;
    logic [2:0][7:0]        calCurSel;
    logic [23:0]            rdData;
    logic                   refused;
  } mtc_state_t;

endpackage

// ===== mtc_threshold_config.sv
// threshold, pulse constant and phase calibration register bank of the metering engine
`timescale 1ns/1ps

module mtc_threshold_config
  import mtc_pkg::*;
(
  input  logic                   sys_clk,
  input  logic                   rst_n,
  input  logic                   regWrite,
  input  logic [7:0]             regAddr,
  input  logic [23:0]            regWrData,
  output logic [23:0]            regRdData,
  output logic                   regWrRefused,
  input  mtc_rms_t               meterRms,
  input  logic [5:0][31:0]       fastCount,
  input  logic [5:0]             pinConstSel,
  input  logic [5:0]             zxRaw,
  input  logic [2:0][23:0]       angleIn,
  output logic [5:0]             pulseOut,
  output logic [5:0]             energyInc,
  output mtc_flags_t             meterFlags,
  output logic [2:0][23:0]       angleOut,
  output logic [2:0][7:0]        calVoltOut,
  output logic [2:0][7:0]        calCurOut,
  output logic [7:0]             calNeutralOut
);

  mtc_state_t st_q;
  mtc_state_t st_d;

  function automatic logic [15:0] magHigh(input logic [31:0] cnt);
    logic [31:0] mag;
    mag = cnt[31] ? (~cnt + 32'h0000_0001) : cnt;
    return mag[31:16];
  endfunction

  function automatic logic regionOrderOk(input logic [15:0] l1,
                                         input logic [15:0] h1,
                                         input logic [15:0] l2,
                                         input logic [15:0] h2);
    return (h1 >= l1) && (h2 >= l2) && (l2 >= l1) && (h2 >= h1);
  endfunction

  function automatic logic isRegionAddr(input logic [7:0] a);
    return (a >= OFS_REGION_LOW1) && (a <= OFS_REGION_HIGH2);
  endfunction

  function automatic logic [15:0] regionView(input logic [31:0] rms);
    return rms[RMS_TOP:REGION_BOT];
  endfunction

  function automatic logic [16:0] lossView(input logic [31:0] rms);
    return rms[RMS_TOP:VLOSS_BOT];
  endfunction

  function automatic logic [31:0] startWide(input logic [15:0] thr);
    return {12'h000, thr, 4'h0};
  endfunction

  function automatic mtc_region_t nextRegion(input mtc_region_t cur,
                                             input logic [15:0] iq,
                                             input mtc_cfg_t c);
    mtc_region_t nr;
    nr = cur;
    if (c.regionLow1 == 16'h0000)
    begin
      nr = RegionOne;
    end
    else
    begin
      unique case (cur)
        RegionOne:
        begin
          if (iq >= c.regionHigh2)
            nr = RegionThree;
          else if (iq >= c.regionHigh1)
            nr = RegionTwo;
        end
        RegionTwo:
        begin
          if (iq >= c.regionHigh2)
            nr = RegionThree;
          else if (iq < c.regionLow1)
            nr = RegionOne;
        end
        RegionThree:
        begin
          if (iq < c.regionLow1)
            nr = RegionOne;
          else if (iq < c.regionLow2)
            nr = RegionTwo;
        end
        default: nr = RegionOne;
      endcase
    end
    return nr;
  endfunction

  function automatic logic [7:0] calByte(input logic [23:0] w, input mtc_region_t r);
    logic [7:0] b;
    b = w[7:0];
    if (r == RegionTwo)
      b = w[15:8];
    else if (r == RegionThree)
      b = w[23:16];
    return b;
  endfunction

  function automatic logic [23:0] readReg(input mtc_cfg_t c, input logic [7:0] a);
    logic [23:0] v;
    v = 24'h000000;
    case (a)
      OFS_PULSE_PRI:    v = {8'h00, c.pulsePri};
      OFS_PULSE_SEC:    v = {8'h00, c.pulseSec};
      OFS_START_PS:     v = {8'h00, c.startPs};
      OFS_START_Q:      v = {8'h00, c.startQ};
      OFS_VOLT_LOSS:    v = {8'h00, c.voltLoss};
      OFS_ZERO_CROSS:   v = {8'h00, c.zeroCross};
      OFS_REGION_LOW1:  v = {8'h00, c.regionLow1};
      OFS_REGION_HIGH1: v = {8'h00, c.regionHigh1};
      OFS_REGION_LOW2:  v = {8'h00, c.regionLow2};
      OFS_REGION_HIGH2: v = {8'h00, c.regionHigh2};
      OFS_ZONE_LOW:     v = {8'h00, c.zoneLow};
      OFS_ZONE_HIGH:    v = {8'h00, c.zoneHigh};
      OFS_CAL_VOLT_A:   v = {16'h0000, c.calVolt[0]};
      OFS_CAL_VOLT_B:   v = {16'h0000, c.calVolt[1]};
      OFS_CAL_VOLT_C:   v = {16'h0000, c.calVolt[2]};
      OFS_CAL_CUR_A:    v = c.calCur[0];
      OFS_CAL_CUR_B:    v = c.calCur[1];
      OFS_CAL_CUR_C:    v = c.calCur[2];
      OFS_CAL_NEUTRAL:  v = {16'h0000, c.calNeutral};
      default:          v = 24'h000000;
    endcase
    return v;
  endfunction

  always_comb
  begin
    logic [15:0] l1;
    logic [15:0] h1;
    logic [15:0] l2;
    logic [15:0] h2;
    logic [15:0] zl;
    logic [15:0] zh;
    logic [15:0] iq;
    logic        vBelow;
    logic        iBelow;
    l1 = st_q.cfg.regionLow1;
    h1 = st_q.cfg.regionHigh1;
    l2 = st_q.cfg.regionLow2;
    h2 = st_q.cfg.regionHigh2;
    zl = st_q.cfg.zoneLow;
    zh = st_q.cfg.zoneHigh;
    iq = 16'h0000;
    vBelow = 1'b0;
    iBelow = 1'b0;
    st_d = st_q;
    st_d.refused = 1'b0;
    st_d.rdData = readReg(st_q.cfg, regAddr);

    if (regWrite)
    begin
      case (regAddr)
        OFS_PULSE_PRI:    st_d.cfg.pulsePri = regWrData[15:0];
        OFS_PULSE_SEC:    st_d.cfg.pulseSec = regWrData[15:0];
        OFS_START_PS:     st_d.cfg.startPs = regWrData[15:0];
        OFS_START_Q:      st_d.cfg.startQ = regWrData[15:0];
        OFS_VOLT_LOSS:    st_d.cfg.voltLoss = regWrData[15:0];
        OFS_ZERO_CROSS:   st_d.cfg.zeroCross = regWrData[15:0];
        OFS_REGION_LOW1:  l1 = regWrData[15:0];
        OFS_REGION_HIGH1: h1 = regWrData[15:0];
        OFS_REGION_LOW2:  l2 = regWrData[15:0];
        OFS_REGION_HIGH2: h2 = regWrData[15:0];
        OFS_ZONE_LOW:     zl = regWrData[15:0];
        OFS_ZONE_HIGH:    zh = regWrData[15:0];
        OFS_CAL_VOLT_A:   st_d.cfg.calVolt[0] = regWrData[7:0];
        OFS_CAL_VOLT_B:   st_d.cfg.calVolt[1] = regWrData[7:0];
        OFS_CAL_VOLT_C:   st_d.cfg.calVolt[2] = regWrData[7:0];
        OFS_CAL_CUR_A:    st_d.cfg.calCur[0] = regWrData;
        OFS_CAL_CUR_B:    st_d.cfg.calCur[1] = regWrData;
        OFS_CAL_CUR_C:    st_d.cfg.calCur[2] = regWrData;
        OFS_CAL_NEUTRAL:  st_d.cfg.calNeutral = regWrData[7:0];
        default:          st_d.rdData = st_d.rdData;
      endcase
      if (isRegionAddr(regAddr))
      begin
        // writing zero to the first low threshold switches regions off
        if ((regAddr == OFS_REGION_LOW1) && (l1 == 16'h0000))
        begin
          h1 = 16'h0000;
          l2 = 16'h0000;
          h2 = 16'h0000;
        end
        if (regionOrderOk(l1, h1, l2, h2))
        begin
          st_d.cfg.regionLow1 = l1;
          st_d.cfg.regionHigh1 = h1;
          st_d.cfg.regionLow2 = l2;
          st_d.cfg.regionHigh2 = h2;
        end
        else
        begin
          st_d.refused = 1'b1;
        end
      end
      if ((regAddr == OFS_ZONE_LOW) || (regAddr == OFS_ZONE_HIGH))
      begin
        if (zh >= zl)
        begin
          st_d.cfg.zoneLow = zl;
          st_d.cfg.zoneHigh = zh;
        end
        else
        begin
          st_d.refused = 1'b1;
        end
      end
    end

    for (int p = 0; p < PULSE_CNT; p++)
    begin
      st_d.pulse[p] = magHigh(fastCount[p]) >=
                      (pinConstSel[p] ? st_q.cfg.pulseSec : st_q.cfg.pulsePri);
      st_d.energy[p] = magHigh(fastCount[p]) >= st_q.cfg.pulsePri;
    end

    for (int ph = 0; ph < PHASE_CNT; ph++)
    begin
      iq = regionView(meterRms.iRms[ph]);
      st_d.region[ph] = nextRegion(st_q.region[ph], iq, st_q.cfg);
      st_d.calCurSel[ph] = calByte(st_q.cfg.calCur[ph], st_d.region[ph]);

      if (st_q.cfg.zoneLow == 16'h0000)
        st_d.flags.zoneStatus[ph] = 1'b0;
      else if (iq >= st_q.cfg.zoneHigh)
        st_d.flags.zoneStatus[ph] = 1'b1;
      else if (iq < st_q.cfg.zoneLow)
        st_d.flags.zoneStatus[ph] = 1'b0;
      st_d.flags.zoneEvent[ph] = (st_q.cfg.zoneLow != 16'h0000) &&
                                 (st_d.flags.zoneStatus[ph] != st_q.flags.zoneStatus[ph]);

      st_d.flags.startPs[ph] = meterRms.iRms[ph] >= startWide(st_q.cfg.startPs);
      st_d.flags.startFundPs[ph] = meterRms.fiRms[ph] >= startWide(st_q.cfg.startPs);
      st_d.flags.startQ[ph] = meterRms.iRms[ph] >= startWide(st_q.cfg.startQ);
      st_d.flags.startFundQ[ph] = meterRms.fiRms[ph] >= startWide(st_q.cfg.startQ);

      st_d.flags.voltLoss[ph] = lossView(meterRms.uRms[ph]) <
                                {1'b0, st_q.cfg.voltLoss};

      vBelow = lossView(meterRms.fuRms[ph]) < {1'b0, st_q.cfg.zeroCross};
      iBelow = lossView(meterRms.fiRms[ph]) < {1'b0, st_q.cfg.zeroCross};
      st_d.flags.zxOut[ph] = zxRaw[ph] && !vBelow;
      st_d.flags.zxOut[ph + 3] = zxRaw[ph + 3] && !iBelow;
      st_d.angle[ph] = (vBelow || iBelow) ? 24'h000000 : angleIn[ph];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.cfg <= CFG_RESET;
      st_q.calCurSel <= {3{RST_CAL_BYTE}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign regRdData     = st_q.rdData;
  assign regWrRefused  = st_q.refused;
  assign pulseOut      = st_q.pulse;
  assign energyInc     = st_q.energy;
  assign meterFlags    = st_q.flags;
  assign angleOut      = st_q.angle;
  assign calVoltOut    = st_q.cfg.calVolt;
  assign calCurOut     = st_q.calCurSel;
  assign calNeutralOut = st_q.cfg.calNeutral;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  pulse_pin_a: assert property (
    ##1 pulseOut[0] == ($past(magHigh(fastCount[0])) >=
      ($past(pinConstSel[0]) ? $past(st_q.cfg.pulseSec) : $past(st_q.cfg.pulsePri))))
    else $error("pulse pin 0 disagrees with its selected constant");

  energy_step_a: assert property (
    ##1 energyInc[5] == ($past(magHigh(fastCount[5])) >= $past(st_q.cfg.pulsePri)))
    else $error("energy step not tied to primary constant");

  start_flag_a: assert property (
    meterRms.iRms[1] < {12'h000, st_q.cfg.startPs, 4'h0} |=> !meterFlags.startPs[1])
    else $error("startup flag set below padded threshold");

  volt_loss_a: assert property (
    (meterRms.uRms[2][27:11] < {1'b0, st_q.cfg.voltLoss}) |=> meterFlags.voltLoss[2])
    else $error("voltage loss not flagged");

  zx_gate_a: assert property (
    (meterRms.fuRms[0][27:11] < {1'b0, st_q.cfg.zeroCross})
      |=> !meterFlags.zxOut[0] && (angleOut[0] == 24'h000000))
    else $error("zero crossing or angle not suppressed");

  region_order_a: assert property (
    regionOrderOk(st_q.cfg.regionLow1, st_q.cfg.regionHigh1,
                  st_q.cfg.regionLow2, st_q.cfg.regionHigh2))
    else $error("region thresholds out of order");

  region_off_a: assert property (
    (st_q.cfg.regionLow1 == 16'h0000) |=>
      (st_q.region[1] == RegionOne) && (calCurOut[1] == $past(st_q.cfg.calCur[1][7:0])))
    else $error("disabled regions not using low byte");

  cal_byte_a: assert property (
    (st_q.region[0] == RegionTwo) |-> calCurOut[0] == $past(st_q.cfg.calCur[0][15:8]))
    else $error("region two not using middle calibration byte");

  zone_order_a: assert property (st_q.cfg.zoneHigh >= st_q.cfg.zoneLow)
    else $error("zone high below zone low");

  zone_set_a: assert property (
    (st_q.cfg.zoneLow != 16'h0000) && (meterRms.iRms[1][27:12] >= st_q.cfg.zoneHigh)
      |=> meterFlags.zoneStatus[1])
    else $error("zone flag not set at high threshold");

  zone_off_a: assert property (
    (st_q.cfg.zoneLow == 16'h0000) |=> !meterFlags.zoneStatus[0] && !meterFlags.zoneEvent[0])
    else $error("zone flag active while disabled");

  refused_keep_a: assert property (regWrRefused |-> st_q.cfg == $past(st_q.cfg))
    else $error("refused write changed a register");

  region_rise_a: assert property (
    (st_q.region[0] == RegionOne) && (st_q.cfg.regionLow1 != 16'h0000) &&
    (meterRms.iRms[0][27:12] < st_q.cfg.regionHigh1) |=> st_q.region[0] == RegionOne)
    else $error("region left below rising boundary");

  region_fall_a: assert property (
    (st_q.region[0] == RegionThree) && (st_q.cfg.regionLow1 != 16'h0000) &&
    (meterRms.iRms[0][27:12] >= st_q.cfg.regionLow2) |=> st_q.region[0] == RegionThree)
    else $error("region left above falling boundary");

  refused_cov: cover property (regWrRefused);
  region3_cov: cover property (st_q.region[0] == RegionThree);
  region2_cov: cover property (st_q.region[0] == RegionTwo);
  zone_cov:    cover property (meterFlags.zoneEvent[1]);
  pulse_cov:   cover property (pulseOut[4] && pinConstSel[4]);

endmodule

// ===== tb_top.sv
// self-checking testbench for the metering threshold and configuration block
`timescale 1ns/1ps
module tb_top;
  import mtc_pkg::*;
  logic             sys_clk;
  logic             rst_n;
  logic             regWrite;
  logic [7:0]       regAddr;
  logic [23:0]      regWrData;
  logic [23:0]      regRdData;
  logic             regWrRefused;
  mtc_rms_t         meterRms;
  logic [5:0][31:0] fastCount;
  logic [5:0]       pinConstSel;
  logic [5:0]       zxRaw;
  logic [2:0][23:0] angleIn;
  logic [5:0]       pulseOut;
  logic [5:0]       energyInc;
  mtc_flags_t       meterFlags;
  logic [2:0][23:0] angleOut;
  logic [2:0][7:0]  calVoltOut;
  logic [2:0][7:0]  calCurOut;
  logic [7:0]       calNeutralOut;
  int               err_total;
  int               n_checks;
  logic [23:0]      rdv;
  logic             refv;
  localparam logic [23:0] RST_TBL [0:19] = '{
    24'h001000, 24'h001000, 24'h000250, 24'h000250, 24'h000400, 24'h000073,
    24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000,
    24'h000080, 24'h000080, 24'h000080, 24'h808080, 24'h808080, 24'h808080,
    24'h000080, 24'h000000};

  mtc_threshold_config i_dut (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .regWrite      (regWrite),
    .regAddr       (regAddr),
    .regWrData     (regWrData),
    .regRdData     (regRdData),
    .regWrRefused  (regWrRefused),
    .meterRms      (meterRms),
    .fastCount     (fastCount),
    .pinConstSel   (pinConstSel),
    .zxRaw         (zxRaw),
    .angleIn       (angleIn),
    .pulseOut      (pulseOut),
    .energyInc     (energyInc),
    .meterFlags    (meterFlags),
    .angleOut      (angleOut),
    .calVoltOut    (calVoltOut),
    .calCurOut     (calCurOut),
    .calNeutralOut (calNeutralOut)
  );

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] d, output logic r);
    @(negedge sys_clk);
    regWrite  = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(negedge sys_clk);
    regWrite = 1'b0;
    r = regWrRefused;
  endtask

  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(negedge sys_clk);
    regAddr = a;
    @(negedge sys_clk);
    d = regRdData;
  endtask

  task automatic t_reset;
    for (int i = 0; i < 20; i++)
    begin
      rd(8'(i), rdv);
      chk("reset value", 32'(rdv), 32'(RST_TBL[i]));
    end
    chk("volt cal out", 32'(calVoltOut), 32'h00808080);
    chk("neutral cal out", 32'(calNeutralOut), 32'h80);
    wr(OFS_CAL_VOLT_B, 24'h00005a, refv);
    chk("volt cal b", 32'(calVoltOut[1]), 32'h5a);
    $display("test reset done");
  endtask

  task automatic t_pulse;
    wr(OFS_PULSE_SEC, 24'h002000, refv);
    pinConstSel = 6'h38;
    fastCount   = {32'he0010000, 32'h20000000, 32'h10000000,
                   32'h0fffffff, 32'hf0000000, 32'h10000000};
    @(negedge sys_clk);
    chk("pulse out", 32'(pulseOut), 32'h13);
    chk("energy inc", 32'(energyInc), 32'h3b);
    wr(OFS_PULSE_PRI, 24'h002000, refv);
    @(negedge sys_clk);
    chk("pulse out pri", 32'(pulseOut), 32'h10);
    chk("energy inc pri", 32'(energyInc), 32'h10);
    fastCount = '0;
    $display("test pulse done");
  endtask

  task automatic t_thresh;
    meterRms.iRms  = {32'h0, 32'h000024ff, 32'h00002500};
    meterRms.fiRms = {32'h00039800, 32'h000397ff, 32'h00039800};
    meterRms.uRms  = {32'h00200000, 32'h001ff800, 32'h0};
    meterRms.fuRms = {3{32'h00039800}};
    zxRaw   = 6'h3f;
    angleIn = {3{24'habcdef}};
    @(negedge sys_clk);
    chk("start ps", 32'(meterFlags.startPs), 32'h1);
    chk("start q", 32'(meterFlags.startQ), 32'h1);
    chk("start fund ps", 32'(meterFlags.startFundPs), 32'h7);
    chk("start fund q", 32'(meterFlags.startFundQ), 32'h7);
    chk("volt loss", 32'(meterFlags.voltLoss), 32'h3);
    chk("zero cross", 32'(meterFlags.zxOut), 32'h2f);
    chk("angle b", 32'(angleOut[1]), 32'h0);
    chk("angle a", 32'(angleOut[0]), 32'habcdef);
    meterRms = '0;
    $display("test thresholds done");
  endtask

  task automatic t_region;
    logic [7:0]  wa [0:6] = '{8'h09, 8'h08, 8'h07, 8'h06, 8'h07, 8'h09, 8'h08};
    logic [15:0] wd [0:6] = '{16'h40, 16'h30, 16'h20, 16'h10, 16'h08, 16'h18, 16'h0c};
    logic [15:0] iqs [0:7] = '{16'h1f, 16'h20, 16'h3f, 16'h40, 16'h30, 16'h2f, 16'h10, 16'h0f};
    logic [7:0]  exb [0:7] = '{8'h11, 8'h22, 8'h22, 8'h33, 8'h33, 8'h22, 8'h22, 8'h11};
    for (int i = 0; i < 7; i++)
    begin
      wr(wa[i], {8'h0, wd[i]}, refv);
      chk("region refused", 32'(refv), 32'(i > 3));
    end
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(6 + i), rdv);
      chk("region kept", 32'(rdv), 32'(wd[3 - i]));
    end
    wr(OFS_CAL_CUR_A, 24'h332211, refv);
    for (int i = 0; i < 8; i++)
    begin
      meterRms.iRms[0] = {4'h0, iqs[i], 12'h0};
      @(negedge sys_clk);
      chk("cal cur a", 32'(calCurOut[0]), 32'(exb[i]));
    end
    meterRms.iRms[0] = {4'h0, 16'h40, 12'h0};
    wr(OFS_REGION_LOW1, 24'h0, refv);
    @(negedge sys_clk);
    chk("cal cur off", 32'(calCurOut[0]), 32'h11);
    rd(OFS_REGION_HIGH2, rdv);
    chk("region cleared", 32'(rdv), 32'h0);
    meterRms = '0;
    $display("test region done");
  endtask

  task automatic t_zone;
    wr(OFS_ZONE_HIGH, 24'h000050, refv);
    chk("zone high ok", 32'(refv), 32'h0);
    wr(OFS_ZONE_LOW, 24'h000020, refv);
    chk("zone low ok", 32'(refv), 32'h0);
    wr(OFS_ZONE_LOW, 24'h000060, refv);
    chk("zone refused", 32'(refv), 32'h1);
    rd(OFS_ZONE_LOW, rdv);
    chk("zone low kept", 32'(rdv), 32'h20);
    meterRms.iRms[1] = {4'h0, 16'h50, 12'h0};
    @(negedge sys_clk);
    chk("zone set", 32'(meterFlags.zoneStatus), 32'h2);
    chk("zone event", 32'(meterFlags.zoneEvent), 32'h2);
    meterRms.iRms[1] = {4'h0, 16'h30, 12'h0};
    @(negedge sys_clk);
    chk("zone hold", 32'(meterFlags.zoneStatus), 32'h2);
    chk("zone event end", 32'(meterFlags.zoneEvent), 32'h0);
    meterRms.iRms[1] = {4'h0, 16'h1f, 12'h0};
    @(negedge sys_clk);
    chk("zone clear", 32'(meterFlags.zoneStatus), 32'h0);
    meterRms.iRms[1] = {4'h0, 16'h60, 12'h0};
    @(negedge sys_clk);
    wr(OFS_ZONE_LOW, 24'h0, refv);
    @(negedge sys_clk);
    chk("zone off", 32'(meterFlags.zoneStatus), 32'h0);
    chk("zone off event", 32'(meterFlags.zoneEvent), 32'h0);
    $display("test zone done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #100us;
    err_total++;
    $display("watchdog expired");
    print_verdict();
  end

  initial
  begin
    err_total   = 0;
    n_checks    = 0;
    rst_n       = 1'b0;
    regWrite    = 1'b0;
    regAddr     = 8'h00;
    regWrData   = 24'h0;
    meterRms    = '0;
    fastCount   = '0;
    pinConstSel = 6'h00;
    zxRaw       = 6'h00;
    angleIn     = '0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_pulse();
    t_thresh();
    t_region();
    t_zone();
    print_verdict();
  end
endmodule
